//--- design/nmt_err_consts.vh
// Constants for the network management and error-control block
`ifndef NMT_ERR_CONSTS_VH
`define NMT_ERR_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL        8'h00
`define REG_HB_PERIOD   8'h04
`define REG_SYNC_ID     8'h08
`define REG_TX_TYPE     8'h0C
`define REG_FAULT       8'h10
`define REG_FAULT_CODE  8'h14
`define REG_INV_LO      8'h18
`define REG_INV_HI      8'h1C
`define REG_STATUS      8'h20

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_NODE_LSB   0
`define CTRL_GUARD_BIT  8
`define CTRL_NODE_RST   7'h01
`define HB_PERIOD_RST   16'h0000
`define SYNC_ID_RST     11'h080
`define TX_TYPE_RST     8'h00

// ----------------------------------------
// Frame identifiers and command words
// ----------------------------------------
`define ID_NMT          11'h000
`define ID_ERRCTL_BASE  11'h700
`define ID_EMCY_BASE    11'h080
`define CMD_START       8'h01
`define CMD_STOP        8'h02
`define CMD_PREOP       8'h80
`define CMD_RST_NODE    8'h81
`define CMD_RST_COMM    8'h82

// ----------------------------------------
// State byte codes
// ----------------------------------------
`define ST_INIT         7'h00
`define ST_STOPPED      7'h04
`define ST_OPER         7'h05
`define ST_PREOP        7'h7F

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ         200
`define MS_NS           1000000
`define CYC_PER_MS      (`MS_NS * `CLK_MHZ / 1000)
`define SYNC_TYPE_MAX   8'hF0

`endif

//--- design/canopen_nmt_error_control.v
// CANopen slave network management and error-control engine
// Behaviour
// R1: NMT command is two data bytes on id 0: command word, node id.
// R2: Node id zero means broadcast; every node executes it.
// R3: Command 0x01 enters operational.
// R4: Command 0x02 enters stopped.
// R5: Command 0x80 enters pre-operational.
// R6: 0x81 full reset, 0x82 communication reset; both pass through init. Only 0x82 restores heartbeat period, SYNC id and guard mode.
// R7: Guard request is remote frame on 0x700+id; answer one byte same id.
// R8: Guard answer bit7 toggles on every successive answer.
// R9: State codes 0x00 init, 0x04 stopped, 0x05 operational, 0x7F pre-op.
// R10: Heartbeat sent periodically, 16-bit period in milliseconds.
// R11: Period zero disables heartbeat; period resets to zero.
// R12: Heartbeat on 0x700+id, one state byte, bit7 cleared.
// R13: Guarding and heartbeat never active together.
// R14: After boot-up send one frame on 0x700+id with byte 0x00.
// R15: SYNC is data-less frame on configurable id, default 0x80.
// R16: Transmit types 1 to 240 are synchronous, sent on SYNC.
// R17: Fault arising or clearing sends eight-byte emergency on 0x80+id.
// R18: Emergency: code LSB first, error register, five-byte fault code LSB first.
// R19: After power-on: init, boot-up frame, then pre-operational automatically.
// R20: PDO only operational; SYNC, SDO, EMCY blocked stopped; error control always. Guard replies and heartbeat are not queued in init.
// R21: Commands for a different non-zero node id are ignored.
// R22: Writing the heartbeat period restarts the heartbeat timer.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "nmt_err_consts.vh"

module canopen_nmt_error_control #(
    parameter integer CYC_MS = `CYC_PER_MS
) (
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire        clk_en_i,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Received frame
    input  wire        rx_valid_i,
    input  wire [10:0] rx_id_i,
    input  wire        rx_rtr_i,
    input  wire [3:0]  rx_dlc_i,
    input  wire [63:0] rx_data_i,
    // Transmit frame
    output reg         tx_valid_o,
    input  wire        tx_ready_i,
    output reg  [10:0] tx_id_o,
    output reg  [3:0]  tx_dlc_o,
    output reg  [63:0] tx_data_o,
    // Service gates and events
    output wire        pdo_enable_o,
    output wire        sdo_enable_o,
    output reg         sync_tpdo_o,
    output reg         node_reset_o,
    output reg         comm_reset_o
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [1:0] S_INIT  = 2'd0;
localparam [1:0] S_PREOP = 2'd1;
localparam [1:0] S_OPER  = 2'd2;
localparam [1:0] S_STOP  = 2'd3;

reg  [1:0]  state_q;
reg         boot_pend_q;
reg  [6:0]  node_q;
reg         guard_mode_q;
reg  [15:0] hb_period_q;
reg  [10:0] sync_id_q;
reg  [7:0]  tx_type_q;
reg         fault_q;
reg  [15:0] fault_code_q;
reg  [39:0] inv_code_q;
reg         fault_seen_q;
reg         toggle_q;
reg         guard_pend_q;
reg         hb_pend_q;
reg         emcy_pend_q;
reg  [31:0] ms_cnt_q;
reg  [15:0] hb_cnt_q;
reg         aw_q;
reg         w_q;
reg  [7:0]  awaddr_q;
reg  [31:0] wdata_q;
reg  [3:0]  wstrb_q;

// ----------------------------------------
// Derived state
// ----------------------------------------
wire [6:0]  st_code = (state_q == S_INIT)  ? `ST_INIT :                      // [R9]
                      (state_q == S_PREOP) ? `ST_PREOP :
                      (state_q == S_OPER)  ? `ST_OPER : `ST_STOPPED;
wire [10:0] ec_id   = `ID_ERRCTL_BASE + {4'h0, node_q};
wire        stopped = (state_q == S_STOP);
wire [31:0] status_w = {22'h0, toggle_q, st_code, state_q};

// ----------------------------------------
// Service gates
// ----------------------------------------
assign pdo_enable_o = (state_q == S_OPER);                                  // [R20]
assign sdo_enable_o = (state_q == S_PREOP) || (state_q == S_OPER);          // [R20]

// ----------------------------------------
// Frame decode
// ----------------------------------------
wire is_nmt   = rx_valid_i && !rx_rtr_i && rx_id_i == `ID_NMT && rx_dlc_i == 4'h2; // [R1]
wire for_me   = rx_data_i[15:8] == 8'h00 ||                                  // [R2]
                rx_data_i[15:8] == {1'b0, node_q};                          // [R21]
wire nmt_go   = is_nmt && for_me && !boot_pend_q;
wire [7:0] cs = rx_data_i[7:0];
wire is_guard = rx_valid_i && rx_rtr_i && rx_id_i == ec_id && guard_mode_q; // [R7] [R13]
wire is_sync  = rx_valid_i && !rx_rtr_i && rx_id_i == sync_id_q && rx_dlc_i == 4'h0 && // [R15]
                !stopped && state_q != S_INIT;                              // [R20]
wire sync_typ = tx_type_q >= 8'h01 && tx_type_q <= `SYNC_TYPE_MAX;          // [R16]

// ----------------------------------------
// Register bus
// ----------------------------------------
wire wr_go = aw_q && w_q && !s_axi_bvalid;
assign s_axi_awready = !aw_q && !s_axi_bvalid;
assign s_axi_wready  = !w_q && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
wire wr_hb = wr_go && wstrb_q[0] && awaddr_q == `REG_HB_PERIOD;
wire wr_ok = awaddr_q == `REG_CTRL || awaddr_q == `REG_HB_PERIOD || awaddr_q == `REG_SYNC_ID ||
             awaddr_q == `REG_TX_TYPE || awaddr_q == `REG_FAULT || awaddr_q == `REG_FAULT_CODE ||
             awaddr_q == `REG_INV_LO || awaddr_q == `REG_INV_HI;

always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        awaddr_q <= 8'h00;
        wdata_q <= 32'h0000_0000;
        wstrb_q <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'b00;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= 2'b00;
        s_axi_rdata <= 32'h0000_0000;
    end else if (clk_en_i) begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `REG_CTRL:       s_axi_rdata <= {23'h0, guard_mode_q, 1'b0, node_q};
                `REG_HB_PERIOD:  s_axi_rdata <= {16'h0, hb_period_q};
                `REG_SYNC_ID:    s_axi_rdata <= {21'h0, sync_id_q};
                `REG_TX_TYPE:    s_axi_rdata <= {24'h0, tx_type_q};
                `REG_FAULT:      s_axi_rdata <= {31'h0, fault_q};
                `REG_FAULT_CODE: s_axi_rdata <= {16'h0, fault_code_q};
                `REG_INV_LO:     s_axi_rdata <= inv_code_q[31:0];
                `REG_INV_HI:     s_axi_rdata <= {24'h0, inv_code_q[39:32]};
                `REG_STATUS:     s_axi_rdata <= status_w;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// Configuration registers
// ----------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        node_q <= `CTRL_NODE_RST;
        guard_mode_q <= 1'b0;
        hb_period_q <= `HB_PERIOD_RST;                                      // [R11]
        sync_id_q <= `SYNC_ID_RST;                                          // [R15]
        tx_type_q <= `TX_TYPE_RST;
        fault_q <= 1'b0;
        fault_code_q <= 16'h0000;
        inv_code_q <= 40'h00_0000_0000;
    end else if (clk_en_i) begin
        if (nmt_go && cs == `CMD_RST_COMM) begin                            // [R6]
            hb_period_q <= `HB_PERIOD_RST;
            sync_id_q <= `SYNC_ID_RST;
            guard_mode_q <= 1'b0;
        end else if (wr_go && wstrb_q[0]) begin
            case (awaddr_q)
                `REG_CTRL: begin
                    node_q <= wdata_q[6:0];
                    guard_mode_q <= wdata_q[`CTRL_GUARD_BIT];               // [R13]
                end
                `REG_HB_PERIOD:  hb_period_q <= wdata_q[15:0];              // [R10]
                `REG_SYNC_ID:    sync_id_q <= wdata_q[10:0];
                `REG_TX_TYPE:    tx_type_q <= wdata_q[7:0];
                `REG_FAULT:      fault_q <= wdata_q[0];
                `REG_FAULT_CODE: fault_code_q <= wdata_q[15:0];
                `REG_INV_LO:     inv_code_q[31:0] <= wdata_q;
                `REG_INV_HI:     inv_code_q[39:32] <= wdata_q[7:0];
                default:         fault_q <= fault_q;
            endcase
        end
    end
end

// ----------------------------------------
// Node state machine and timers
// ----------------------------------------
wire ms_tick = ms_cnt_q == CYC_MS - 1;
wire hb_on   = hb_period_q != 16'h0000 && !guard_mode_q;                    // [R11] [R13]
wire hb_due  = hb_on && ms_tick && hb_cnt_q >= hb_period_q - 16'h0001;
wire emcy_ev = fault_q != fault_seen_q;
wire tx_fire = tx_valid_o && tx_ready_i;
wire guard_set = is_guard && state_q != S_INIT;
wire hb_set    = hb_due && state_q != S_INIT;
wire emcy_set  = emcy_ev && !stopped && state_q != S_INIT;                  // [R20]

// ----------------------------------------
// Millisecond base and heartbeat interval
// ----------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        ms_cnt_q <= 32'h0000_0000;
        hb_cnt_q <= 16'h0000;
    end else if (clk_en_i) begin
        if (ms_tick || wr_hb)
            ms_cnt_q <= 32'h0000_0000;
        else
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
        if (wr_hb || !hb_on || hb_due)                                      // [R22]
            hb_cnt_q <= 16'h0000;
        else if (ms_tick)
            hb_cnt_q <= hb_cnt_q + 16'h0001;
    end
end

// ----------------------------------------
// Node state and transmit arbiter
// ----------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        state_q <= S_INIT;
        boot_pend_q <= 1'b1;
        toggle_q <= 1'b0;
        guard_pend_q <= 1'b0;
        hb_pend_q <= 1'b0;
        emcy_pend_q <= 1'b0;
        fault_seen_q <= 1'b0;
        tx_valid_o <= 1'b0;
        tx_id_o <= 11'h000;
        tx_dlc_o <= 4'h0;
        tx_data_o <= 64'h0000_0000_0000_0000;
        sync_tpdo_o <= 1'b0;
        node_reset_o <= 1'b0;
        comm_reset_o <= 1'b0;
    end else if (clk_en_i) begin
        sync_tpdo_o <= is_sync && sync_typ;                                 // [R16]
        node_reset_o <= nmt_go && cs == `CMD_RST_NODE;                      // [R6]
        comm_reset_o <= nmt_go && cs == `CMD_RST_COMM;
        if (nmt_go) begin
            case (cs)
                `CMD_START: state_q <= S_OPER;                              // [R3]
                `CMD_STOP:  state_q <= S_STOP;                              // [R4]
                `CMD_PREOP: state_q <= S_PREOP;                             // [R5]
                `CMD_RST_NODE, `CMD_RST_COMM: begin                         // [R6]
                    state_q <= S_INIT;
                    boot_pend_q <= 1'b1;
                    toggle_q <= 1'b0;
                end
                default: state_q <= state_q;
            endcase
        end
        if (hb_set)                                                         // [R10]
            hb_pend_q <= 1'b1;
        if (guard_set)
            guard_pend_q <= 1'b1;
        if (emcy_ev)                                                        // [R17]
            fault_seen_q <= fault_q;
        if (emcy_set)
            emcy_pend_q <= 1'b1;
        // Transmit arbiter
        if (tx_fire)
            tx_valid_o <= 1'b0;
        else if (!tx_valid_o) begin
            if (boot_pend_q) begin
                tx_valid_o <= 1'b1;                                         // [R14]
                tx_id_o <= ec_id;
                tx_dlc_o <= 4'h1;
                tx_data_o <= 64'h0000_0000_0000_0000;
                boot_pend_q <= 1'b0;
                state_q <= S_PREOP;                                         // [R19]
            end else if (guard_pend_q) begin
                tx_valid_o <= 1'b1;                                         // [R7]
                tx_id_o <= ec_id;
                tx_dlc_o <= 4'h1;
                tx_data_o <= {56'h0, toggle_q, st_code};                    // [R8]
                toggle_q <= ~toggle_q;                                      // [R8]
                guard_pend_q <= guard_set;
            end else if (hb_pend_q) begin
                tx_valid_o <= 1'b1;                                         // [R12]
                tx_id_o <= ec_id;
                tx_dlc_o <= 4'h1;
                tx_data_o <= {56'h0, 1'b0, st_code};
                hb_pend_q <= hb_set;
            end else if (emcy_pend_q) begin
                tx_valid_o <= 1'b1;                                         // [R17]
                tx_id_o <= `ID_EMCY_BASE + {4'h0, node_q};
                tx_dlc_o <= 4'h8;
                tx_data_o <= fault_q ? {inv_code_q, 7'h0, 1'b1, fault_code_q} : // [R18]
                             64'h0000_0000_0000_0000;
                emcy_pend_q <= emcy_set;
            end
        end
    end
end

endmodule // canopen_nmt_error_control

//--- tb/nmt_err_chk.sv
// Assertion checker for the NMT and error-control block
`timescale 1ns/1ps
module nmt_err_chk (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        clk_en_i,
    input wire logic        rx_valid_i,
    input wire logic [10:0] rx_id_i,
    input wire logic        rx_rtr_i,
    input wire logic [3:0]  rx_dlc_i,
    input wire logic [63:0] rx_data_i,
    input wire logic        tx_valid_o,
    input wire logic        tx_ready_i,
    input wire logic [10:0] tx_id_o,
    input wire logic [3:0]  tx_dlc_o,
    input wire logic [63:0] tx_data_o,
    input wire logic        pdo_enable_o,
    input wire logic        sdo_enable_o,
    input wire logic        sync_tpdo_o,
    input wire logic        node_reset_o,
    input wire logic        comm_reset_o
);
    // Broadcast command frame seen
    wire bc = rx_valid_i && clk_en_i && rx_id_i == 11'h000 && !rx_rtr_i && rx_dlc_i == 4'h2
              && rx_data_i[15:8] == 8'h00;
    wire [7:0] cmd = rx_data_i[7:0];
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_boot; $rose(rst_n_i) |=> tx_valid_o && tx_id_o[10:7] == 4'hE && tx_dlc_o == 4'h1
        && tx_data_o[7:0] == 8'h00; endproperty
    a_boot: assert property (p_boot) else $error("boot frame missing");
    property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_id_o) && $stable(tx_data_o); endproperty
    a_hold: assert property (p_hold) else $error("tx frame changed while waiting");
    property p_nrst; bc && cmd == 8'h81 |=> node_reset_o ##1 !node_reset_o; endproperty
    a_nrst: assert property (p_nrst) else $error("node reset pulse wrong");
    property p_crst; bc && cmd == 8'h82 |=> comm_reset_o ##1 !comm_reset_o; endproperty
    a_crst: assert property (p_crst) else $error("comm reset pulse wrong");
    property p_start; bc && cmd == 8'h01 |-> ##[1:3] pdo_enable_o; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_stop; bc && cmd == 8'h02 |-> ##[1:3] !sdo_enable_o && !pdo_enable_o; endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");
    property p_preop; bc && cmd == 8'h80 |-> ##[1:3] sdo_enable_o && !pdo_enable_o; endproperty
    a_preop: assert property (p_preop) else $error("pre-op not taken");
    property p_emcy; tx_valid_o && tx_id_o[10:7] == 4'h1 |-> tx_dlc_o == 4'h8; endproperty
    a_emcy: assert property (p_emcy) else $error("emergency length wrong");
    property p_ectl; tx_valid_o && tx_id_o[10:7] == 4'hE |-> tx_dlc_o == 4'h1; endproperty
    a_ectl: assert property (p_ectl) else $error("state frame length wrong");
    property p_sync; sync_tpdo_o |-> $past(rx_valid_i) && !$past(rx_rtr_i) && $past(rx_dlc_i) == 4'h0
        && $past(sdo_enable_o); endproperty
    a_sync: assert property (p_sync) else $error("sync pulse without sync frame");
    c_emcy: cover property (tx_valid_o && tx_ready_i && tx_dlc_o == 4'h8);
    c_sync: cover property (sync_tpdo_o);
    c_nrst: cover property (node_reset_o);
endmodule // nmt_err_chk

//--- tb/can_master_model.sv
// Network master model: sends frames, accepts replies
`timescale 1ns/1ps
module can_master_model (
    input  wire logic        clk_i,
    input  wire logic        slow_i,
    output logic             rx_valid_o,
    output logic [10:0]      rx_id_o,
    output logic             rx_rtr_o,
    output logic [3:0]       rx_dlc_o,
    output logic [63:0]      rx_data_o,
    output logic             tx_ready_o
);
    initial {rx_valid_o, rx_id_o, rx_rtr_o, rx_dlc_o, rx_data_o, tx_ready_o} = '0;
    // Ready prompt or randomly stalled
    always @(posedge clk_i) tx_ready_o <= slow_i ? ($urandom % 3 == 0) : 1'b1;
    // One-cycle frame, lines inverted once released
    task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [63:0] d);
        @(posedge clk_i);
        {rx_valid_o, rx_id_o, rx_rtr_o, rx_dlc_o, rx_data_o} <= {1'b1, id, rtr, dlc, d};
        @(posedge clk_i);
        {rx_valid_o, rx_id_o, rx_rtr_o, rx_dlc_o, rx_data_o} <= {1'b0, ~id, ~rtr, ~dlc, ~d};
    endtask
    task automatic nmt(input logic [7:0] cmd, input logic [7:0] node);
        send(11'h000, 1'b0, 4'h2, {48'h0, node, cmd});
    endtask
    task automatic guard_req(input logic [10:0] node);
        send(11'h700 + node, 1'b1, 4'h0, 64'h0);
    endtask
    task automatic sync_req;
        send(11'h080, 1'b0, 4'h0, 64'h0);
    endtask
endmodule // can_master_model

//--- tb/canopen_nmt_error_control_tb_top.sv
// Testbench top for the NMT and error-control block
`timescale 1ns/1ps
module canopen_nmt_error_control_tb_top;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, slow = 1'b0, tog = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0, rx_dlc_i, tx_dlc_o;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        rx_valid_i, rx_rtr_i, tx_valid_o, tx_ready_i;
    logic        pdo_enable_o, sdo_enable_o, sync_tpdo_o, node_reset_o, comm_reset_o;
    logic [10:0] rx_id_i, tx_id_o;
    logic [63:0] rx_data_i, tx_data_o;
    logic [78:0] q[$];
    logic [22:0] tab [0:5] = '{{8'h01, 8'h00, 7'h05}, {8'h02, 8'h02, 7'h05}, {8'h02, 8'h00, 7'h04},
                               {8'h80, 8'h00, 7'h7F}, {8'h01, 8'h01, 7'h05}, {8'h80, 8'h01, 7'h7F}};
    logic [7:0]  ty;
    logic [15:0] ec;
    logic [39:0] iv;
    logic [6:0]  st;
    int          n_fail = 0, checks_done = 0, cyc = 0, n_sync = 0, exp_sync = 0, n_nrst = 0, n_crst = 0;
    int unsigned seed_v;
    always #2.5 clk_sys_i = ~clk_sys_i;
    canopen_nmt_error_control #(.CYC_MS(4)) dut (.clk_sys_i, .rst_n_i, .clk_en_i(1'b1),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid_i, .rx_id_i,
        .rx_rtr_i, .rx_dlc_i, .rx_data_i, .tx_valid_o, .tx_ready_i, .tx_id_o, .tx_dlc_o, .tx_data_o,
        .pdo_enable_o, .sdo_enable_o, .sync_tpdo_o, .node_reset_o, .comm_reset_o);
    can_master_model mdl (.clk_i(clk_sys_i), .slow_i(slow), .rx_valid_o(rx_valid_i), .rx_id_o(rx_id_i),
        .rx_rtr_o(rx_rtr_i), .rx_dlc_o(rx_dlc_i), .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i));
    // ----------------------------------------
    // Compare and close
    // ----------------------------------------
    task automatic chk(input string nm, input logic [78:0] got, input logic [78:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Register bus master
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        logic ta, tw, v;
        logic [1:0] r;
        @(posedge clk_sys_i);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge clk_sys_i);
            {ta, tw, v, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge clk_sys_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!v);
        s_axi_bready <= 1'b0;
        chk("bresp", r, rsp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] rsp);
        logic t, v;
        logic [33:0] r;
        @(posedge clk_sys_i);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(negedge clk_sys_i);
            {t, v, r} = {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
            @(posedge clk_sys_i);
            if (t) s_axi_arvalid <= 1'b0;
        end while (!v);
        s_axi_rready <= 1'b0;
        chk("rdata", r[31:0] & m, e);
        chk("rresp", r[33:32], rsp);
    endtask
    task automatic drain;
        while (q.size() != 0) @(posedge clk_sys_i);
    endtask
    // ----------------------------------------
    // Monitors
    // ----------------------------------------
    always @(posedge clk_sys_i) begin
        cyc++;
        if (sync_tpdo_o === 1'b1) n_sync++;
        if (node_reset_o === 1'b1) n_nrst++;
        if (comm_reset_o === 1'b1) n_crst++;
        if (rst_n_i && tx_valid_o === 1'b1 && tx_ready_i) begin
            if (q.size() == 0) begin
                n_fail++;
                $display("Error tx_frame expected none seen id %h", tx_id_o);
            end else chk("tx_frame", {tx_id_o, tx_dlc_o, tx_data_o}, q.pop_front());
        end
        if (cyc == 20000) begin
            n_fail++;
            finish_test;
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed_v = $urandom(33);
        q.push_back({11'h701, 4'h1, 64'h0});
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        slow <= 1'b1;
        drain;
        rd(8'h20, 32'h0000_01FC, 32'h0000_01FC, 2'b00);
        rd(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000, 2'b10);
        wr(8'h3C, 32'h0000_0001, 2'b10);
        wr(8'h00, 32'h0000_0101, 2'b00);
        ty = 8'($urandom_range(240, 1));
        wr(8'h0C, {24'h0, ty}, 2'b00);
        for (int i = 0; i < 6; i++) begin
            st = tab[i][6:0];
            mdl.nmt(tab[i][22:15], tab[i][14:7]);
            repeat (3) @(posedge clk_sys_i);
            q.push_back({11'h701, 4'h1, 56'h0, tog, st});
            tog = ~tog;
            mdl.guard_req(11'h001);
            mdl.sync_req;
            exp_sync += (st != 7'h04);
            drain;
            chk("pdo_enable", pdo_enable_o, st == 7'h05);
        end
        repeat (2) @(posedge clk_sys_i);
        chk("sync_pulses", n_sync, exp_sync);
        wr(8'h0C, 32'h0000_00F1, 2'b00);
        mdl.sync_req;
        repeat (2) @(posedge clk_sys_i);
        chk("sync_async", n_sync, exp_sync);
        ec = 16'($urandom);
        iv = {8'($urandom), 32'($urandom)};
        wr(8'h14, {16'h0, ec}, 2'b00);
        wr(8'h18, iv[31:0], 2'b00);
        wr(8'h1C, {24'h0, iv[39:32]}, 2'b00);
        q.push_back({11'h081, 4'h8, iv, 8'h01, ec});
        wr(8'h10, 32'h0000_0001, 2'b00);
        drain;
        q.push_back({11'h081, 4'h8, 64'h0});
        wr(8'h10, 32'h0000_0000, 2'b00);
        drain;
        slow <= 1'b0;
        wr(8'h00, 32'h0000_0001, 2'b00);
        repeat (3) q.push_back({11'h701, 4'h1, 64'h7F});
        wr(8'h04, 32'h0000_0002, 2'b00);
        drain;
        wr(8'h04, 32'h0000_0000, 2'b00);
        mdl.guard_req(11'h001);
        repeat (40) @(posedge clk_sys_i);
        q.push_back({11'h701, 4'h1, 64'h0});
        mdl.nmt(8'h82, 8'h00);
        drain;
        q.push_back({11'h701, 4'h1, 64'h0});
        mdl.nmt(8'h81, 8'h00);
        drain;
        chk("resets", {n_nrst, n_crst}, {32'd1, 32'd1});
        rd(8'h20, 32'h0000_01FC, 32'h0000_01FC, 2'b00);
        finish_test;
    end
endmodule // canopen_nmt_error_control_tb_top
bind canopen_nmt_error_control nmt_err_chk chk (.clk_sys_i, .rst_n_i, .clk_en_i, .rx_valid_i, .rx_id_i,
    .rx_rtr_i, .rx_dlc_i, .rx_data_i, .tx_valid_o, .tx_ready_i, .tx_id_o, .tx_dlc_o, .tx_data_o,
    .pdo_enable_o, .sdo_enable_o, .sync_tpdo_o, .node_reset_o, .comm_reset_o);
